// [hdl/irt_cfg.svh]
// Purpose: constants for the ingress rate table access block
// Assumes: register numbers are word indices on the switch register port
// Notes:   table entries are 16 bits, reached only through the command register
// How it works
// - table holds 24 rate entries plus committed and excess burst, 16 bits each
// - excess burst limit in bytes, resets to 0x0600, excess bursts dropped
// - committed burst limit in bytes, resets to 0x0600, randomly discarded
// - buckets start at default burst; lower limit caps only after draining
// - rate entry gives time per byte as (value+1)*20 ns, resets 0x0014
// - pending flag bit 0 high during a command, self-clears when done
// - write data bits 15:0 feed the next write command, reset zero
// - read data bits 15:0 hold last read result, read-only, reset zero
// - command register write starts access; bit 7 one reads, zero writes
// - type bits 6:5: 01 rate, 10 committed burst, 11 excess burst, 00 reserved
// - index bits 4:0 select one of 24 rate entries
`ifndef IRT_CFG_SVH
`define IRT_CFG_SVH
`define IRT_IDX_CFG       16'h184a
`define IRT_IDX_CMD       16'h184b
`define IRT_IDX_STS       16'h184c
`define IRT_IDX_WDATA     16'h184d
`define IRT_IDX_RDATA     16'h184e
`define IRT_CMD_RNW_BIT   7
`define IRT_CMD_TYPE_HI   6
`define IRT_CMD_TYPE_LO   5
`define IRT_CMD_IDX_HI    4
`define IRT_STS_PEND_BIT  0
`define IRT_BURST_RST     16'h0600
`define IRT_RATE_RST      16'h0014
`define IRT_DATA_RST      16'h0000
`define IRT_RATE_UNIT_NS  20
`define IRT_CLK_NS        10
`define IRT_RATE_UNIT_CYC (`IRT_RATE_UNIT_NS / `IRT_CLK_NS)
`endif

// [hdl/irt_pkg.sv]
// Purpose: types for the ingress rate table access block
// Assumes: nothing
// Notes:   none
package irt_pkg;
   typedef enum logic [1:0] {IRT_TY_RSVD, IRT_TY_RATE, IRT_TY_CBS, IRT_TY_EBS} irt_type_t;
   typedef enum {IRT_IDLE, IRT_EXEC} irt_state_t;
endpackage : irt_pkg

// [hdl/irt_table.sv]
// Purpose: indirect access and storage of the ingress rate metering table
// Assumes: single-cycle register port on the switch core clock
// Notes:   a command completes on the edge after it is taken; pending is high for that cycle
`timescale 1ns/1ps
`default_nettype none
`include "irt_cfg.svh"
module irt_table #(
   parameter int NUM_RATE = 24,
   parameter int DW       = 16
) (
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            reset,
   // register port
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [15:0]     reg_addr,
   input  wire logic [31:0]     reg_wdata,
   output var  logic [31:0]     reg_rdata,
   output var  logic            reg_rvalid,
   // metering datapath view
   input  wire logic [4:0]      meter_idx,
   output var  logic [DW-1:0]   meter_rate,
   output var  logic [DW-1:0]   meter_cbs,
   output var  logic [DW-1:0]   meter_ebs,
   output var  logic [1:0]      rate_mode,
   output var  logic            rate_enable,
   output var  logic            op_pending
);
   import irt_pkg::*;

   typedef struct packed {
      irt_state_t          st;
      logic                rnw;
      irt_type_t           ty;
      logic [4:0]          idx;
      logic [DW-1:0]       wdata;
      logic [DW-1:0]       rdata;
      logic [DW-1:0]       cbs;
      logic [DW-1:0]       ebs;
      logic [NUM_RATE-1:0][DW-1:0] rate;
      logic [2:0]          cfg;
      logic [31:0]         bus;
      logic                bvld;
      logic [DW-1:0]       mrate;
      logic                pend;
   } irt_state_s_t;

   irt_state_s_t s_reg;
   irt_state_s_t s_next;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
      return a == idx;
   endfunction : hit

   always_comb
   begin
      s_next      = s_reg;
      s_next.bvld = reg_rd;
      s_next.bus  = 32'h0;
      if (reg_rd)
      begin
         if (hit(reg_addr, `IRT_IDX_CFG))   s_next.bus = {29'h0, s_reg.cfg};
         if (hit(reg_addr, `IRT_IDX_STS))   s_next.bus = {31'h0, s_reg.pend};
         if (hit(reg_addr, `IRT_IDX_WDATA)) s_next.bus = {16'h0, s_reg.wdata};
         if (hit(reg_addr, `IRT_IDX_RDATA)) s_next.bus = {16'h0, s_reg.rdata};
      end
      case (s_reg.st)
         IRT_IDLE:
         begin
            if (reg_wr && hit(reg_addr, `IRT_IDX_CFG))
               s_next.cfg = reg_wdata[2:0];
            if (reg_wr && hit(reg_addr, `IRT_IDX_WDATA))
               s_next.wdata = reg_wdata[DW-1:0];
            if (reg_wr && hit(reg_addr, `IRT_IDX_CMD))
            begin
               s_next.rnw  = reg_wdata[`IRT_CMD_RNW_BIT];
               s_next.ty   = irt_type_t'(reg_wdata[`IRT_CMD_TYPE_HI:`IRT_CMD_TYPE_LO]);
               s_next.idx  = reg_wdata[`IRT_CMD_IDX_HI:0];
               s_next.pend = 1'b1;
               s_next.st   = IRT_EXEC;
            end
         end
         IRT_EXEC:
         begin
            // out-of-range index or reserved type writes nothing, loads zero into read data on a read, and still completes
            if (s_reg.rnw)
            begin
               case (s_reg.ty)
                  IRT_TY_RATE: s_next.rdata = (int'(s_reg.idx) < NUM_RATE) ?
                                              s_reg.rate[s_reg.idx] : `IRT_DATA_RST;
                  IRT_TY_CBS:  s_next.rdata = s_reg.cbs;
                  IRT_TY_EBS:  s_next.rdata = s_reg.ebs;
                  default:     s_next.rdata = `IRT_DATA_RST;
               endcase
            end
            else
            begin
               case (s_reg.ty)
                  IRT_TY_RATE: if (int'(s_reg.idx) < NUM_RATE)
                                  s_next.rate[s_reg.idx] = s_reg.wdata;
                  IRT_TY_CBS:  s_next.cbs = s_reg.wdata;
                  IRT_TY_EBS:  s_next.ebs = s_reg.wdata;
                  default:     s_next.cbs = s_reg.cbs;
               endcase
            end
            s_next.pend = 1'b0;
            s_next.st   = IRT_IDLE;
         end
         default: s_next.st = IRT_IDLE;
      endcase
      s_next.mrate = (int'(meter_idx) < NUM_RATE) ? s_next.rate[meter_idx] : `IRT_RATE_RST;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_reg       <= '0;
         s_reg.st    <= IRT_IDLE;
         s_reg.ty    <= IRT_TY_RSVD;
         s_reg.cbs   <= `IRT_BURST_RST;
         s_reg.ebs   <= `IRT_BURST_RST;
         s_reg.rate  <= {NUM_RATE{`IRT_RATE_RST}};
         s_reg.mrate <= `IRT_RATE_RST;
      end
      else
         s_reg <= s_next;
   end

   // datapath sees the entry value; time per byte is (value+1) rate units
   assign reg_rdata   = s_reg.bus;
   assign reg_rvalid  = s_reg.bvld;
   assign meter_rate  = s_reg.mrate;
   assign meter_cbs   = s_reg.cbs;
   assign meter_ebs   = s_reg.ebs;
   assign rate_mode   = s_reg.cfg[2:1];
   assign rate_enable = s_reg.cfg[0];
   assign op_pending  = s_reg.pend;

   // pending rises on the edge that takes the command and drops one edge later
   property pend_one_cycle;
      @(posedge mclk) disable iff (reset)
      (reg_wr && hit(reg_addr, `IRT_IDX_CMD) && !op_pending) |=> op_pending ##1 !op_pending;
   endproperty
   pend_pulse_a: assert property (pend_one_cycle) else $error("pending not one cycle");

   sequence wr_cmd_cbs;
      reg_wr && hit(reg_addr, `IRT_IDX_CMD) && !op_pending &&
      reg_wdata[7:5] == 3'b010;
   endsequence
   cbs_write_a: assert property (@(posedge mclk) disable iff (reset)
      wr_cmd_cbs |=> ##1 (meter_cbs == $past(s_reg.wdata, 2)))
      else $error("committed burst write lost");

   sequence wr_cmd_ebs;
      reg_wr && hit(reg_addr, `IRT_IDX_CMD) && !op_pending &&
      reg_wdata[7:5] == 3'b011;
   endsequence
   ebs_write_a: assert property (@(posedge mclk) disable iff (reset)
      wr_cmd_ebs |=> ##1 (meter_ebs == $past(s_reg.wdata, 2)))
      else $error("excess burst write lost");

   sequence rd_cmd_cbs;
      reg_wr && hit(reg_addr, `IRT_IDX_CMD) && !op_pending &&
      reg_wdata[7:5] == 3'b110;
   endsequence
   rd_cbs_a: assert property (@(posedge mclk) disable iff (reset)
      rd_cmd_cbs |=> ##1 (s_reg.rdata == meter_cbs))
      else $error("read of committed burst wrong");

   sts_read_a: assert property (@(posedge mclk) disable iff (reset)
      (reg_rd && hit(reg_addr, `IRT_IDX_STS))
      |=> reg_rvalid && reg_rdata == {31'h0, $past(op_pending)})
      else $error("status read wrong");

   wdata_load_a: assert property (@(posedge mclk) disable iff (reset)
      (reg_wr && hit(reg_addr, `IRT_IDX_WDATA) && !op_pending)
      |=> s_reg.wdata == $past(reg_wdata[15:0]))
      else $error("write data not loaded");

   rdata_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !op_pending |=> $stable(s_reg.rdata))
      else $error("read data changed while idle");

   rate_reset_a: assert property (@(posedge mclk)
      $past(reset) |-> meter_cbs == `IRT_BURST_RST && meter_ebs == `IRT_BURST_RST
                       && !op_pending)
      else $error("reset values wrong");

   // rate commands only store or fetch when the index names a real entry
   sequence wr_cmd_rate;
      reg_wr && hit(reg_addr, `IRT_IDX_CMD) && !op_pending &&
      reg_wdata[7:5] == 3'b001 && int'(reg_wdata[4:0]) < NUM_RATE;
   endsequence
   rate_write_a: assert property (@(posedge mclk) disable iff (reset)
      wr_cmd_rate |=> ##1 (s_reg.rate[s_reg.idx] == s_reg.wdata))
      else $error("rate entry write lost");

   sequence rd_cmd_rate;
      reg_wr && hit(reg_addr, `IRT_IDX_CMD) && !op_pending &&
      reg_wdata[7:5] == 3'b101 && int'(reg_wdata[4:0]) < NUM_RATE;
   endsequence
   rate_read_a: assert property (@(posedge mclk) disable iff (reset)
      rd_cmd_rate |=> ##1 (s_reg.rdata == s_reg.rate[s_reg.idx]))
      else $error("rate entry read wrong");

   sequence rd_cmd_ebs;
      reg_wr && hit(reg_addr, `IRT_IDX_CMD) && !op_pending &&
      reg_wdata[7:5] == 3'b111;
   endsequence
   ebs_read_a: assert property (@(posedge mclk) disable iff (reset)
      rd_cmd_ebs |=> ##1 (s_reg.rdata == meter_ebs))
      else $error("read of excess burst wrong");

   // a read answer stands exactly one cycle, so software must take it then
   rvalid_pulse_a: assert property (@(posedge mclk) disable iff (reset)
      reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after strobe");

   // the datapath view trails the index by one cycle, fresh writes included
   meter_view_a: assert property (@(posedge mclk) disable iff (reset)
      (int'(meter_idx) < NUM_RATE) |=> meter_rate == s_reg.rate[$past(meter_idx)])
      else $error("metering view stale");
   meter_range_a: assert property (@(posedge mclk) disable iff (reset)
      (int'(meter_idx) >= NUM_RATE) |=> meter_rate == `IRT_RATE_RST)
      else $error("out of range index not defaulted");
endmodule : irt_table
`default_nettype wire

// [testbench/ingress_rate_table_access_tb_top.sv]
// Purpose: self-checking bench for the ingress rate table access block
// Assumes: register port strobes are single-cycle pulses, driven at the falling edge
// Notes:   table entries are reached only through command, write data and read data
`timescale 1ns/1ps
`default_nettype none
`include "irt_cfg.svh"
module ingress_rate_table_access_tb_top;
   import irt_pkg::*;
   logic        mclk         = 1'b0;
   logic        reset        = 1'b1;
   logic        reg_wr       = 1'b0;
   logic        reg_rd       = 1'b0;
   logic [15:0] reg_addr     = 16'h0000;
   logic [31:0] reg_wdata    = 32'h0000_0000;
   logic [4:0]  meter_idx    = 5'h00;
   logic [31:0] reg_rdata;
   logic        reg_rvalid;
   logic [15:0] meter_rate;
   logic [15:0] meter_cbs;
   logic [15:0] meter_ebs;
   logic [1:0]  rate_mode;
   logic        rate_enable;
   logic        op_pending;
   logic [31:0] rv;
   int          n_errors     = 0;
   int          total_checks = 0;
   always #5 mclk = ~mclk;
   irt_table DUT (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .meter_idx(meter_idx), .meter_rate(meter_rate),
      .meter_cbs(meter_cbs), .meter_ebs(meter_ebs), .rate_mode(rate_mode),
      .rate_enable(rate_enable), .op_pending(op_pending));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      check({31'h0, reg_rvalid}, 32'h1);
      d = reg_rdata;
   endtask : reg_read
   // the wait is bounded so a stuck pending flag shows up as a mismatch, not a hang
   task automatic run_cmd(input logic [7:0] c);
      int k;
      reg_write(`IRT_IDX_CMD, {24'h0, c});
      check({31'h0, op_pending}, 32'h1);
      k = 0;
      while (op_pending !== 1'b0 && k < 20)
      begin
         @(negedge mclk);
         k++;
      end
      check({31'h0, op_pending}, 32'h0);
   endtask : run_cmd
   task automatic tbl_read(input logic [7:0] c, input logic [31:0] exp);
      logic [31:0] v;
      run_cmd(c | 8'h80);
      reg_read(`IRT_IDX_RDATA, v);
      check(v, exp);
   endtask : tbl_read
   task automatic tbl_write(input logic [7:0] c, input logic [31:0] d);
      reg_write(`IRT_IDX_WDATA, d);
      run_cmd(c);
   endtask : tbl_write
   logic [7:0]  cmds [7] = '{8'h00, 8'h38, 8'h24, 8'h25, 8'h40, 8'h60, 8'h37};
   logic [31:0] exps [7] = '{32'h0, 32'h0, 32'h14, 32'h1111, 32'h200, 32'h300, 32'habcd};
   initial
   begin
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      check({16'h0, meter_cbs}, 32'h0600);
      check({16'h0, meter_ebs}, 32'h0600);
      check({16'h0, meter_rate}, 32'h0014);
      reg_read(`IRT_IDX_STS, rv);
      check(rv, 32'h0);
      reg_read(`IRT_IDX_WDATA, rv);
      check(rv, 32'h0);
      reg_read(`IRT_IDX_RDATA, rv);
      check(rv, 32'h0);
      for (int i = 0; i < 24; i++)
         tbl_read(8'h20 | 8'(i), 32'h0014);
      tbl_read(8'h40, 32'h0600);
      tbl_read(8'h60, 32'h0600);
      tbl_write(8'h37, 32'hffff_abcd);
      reg_read(`IRT_IDX_WDATA, rv);
      check(rv, 32'h0000_abcd);
      tbl_write(8'h25, 32'h0000_1111);
      tbl_write(8'h40, 32'h0000_0200);
      tbl_write(8'h60, 32'h0000_0300);
      check({16'h0, meter_cbs}, 32'h0200);
      check({16'h0, meter_ebs}, 32'h0300);
      meter_idx = 5'h17;
      @(negedge mclk);
      check({16'h0, meter_rate}, 32'habcd);
      meter_idx = 5'h1f;
      @(negedge mclk);
      check({16'h0, meter_rate}, 32'h0014);
      for (int i = 0; i < 7; i++)
         tbl_read(cmds[i], exps[i]);
      reg_write(`IRT_IDX_RDATA, 32'h5555);
      reg_read(`IRT_IDX_RDATA, rv);
      check(rv, 32'h0000_abcd);
      reg_read(16'h1850, rv);
      check(rv, 32'h0);
      reg_write(`IRT_IDX_CFG, 32'h7);
      @(negedge mclk);
      check({30'h0, rate_mode}, 32'h3);
      check({31'h0, rate_enable}, 32'h1);
      tbl_write(8'h60, 32'h0000_0600);
      check({16'h0, meter_ebs}, 32'h0600);
      // a second reset must undo programmed entries, not only the power-up state
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      check({16'h0, meter_cbs}, 32'h0600);
      check({16'h0, meter_ebs}, 32'h0600);
      check({16'h0, meter_rate}, 32'h0014);
      check({31'h0, op_pending}, 32'h0);
      check({30'h0, rate_mode}, 32'h0);
      reg_read(`IRT_IDX_WDATA, rv);
      check(rv, 32'h0);
      reg_read(`IRT_IDX_RDATA, rv);
      check(rv, 32'h0);
      tbl_read(8'h37, 32'h0014);
      tbl_read(8'h25, 32'h0014);
      final_report();
   end
   initial
   begin
      #200000;
      n_errors++;
      final_report();
   end
endmodule : ingress_rate_table_access_tb_top
`default_nettype wire
